// >>> verilog/temp_monitor_pkg.sv
/*
 * Shared constants, types and register map of the two-channel temperature monitor core.
 * Assumes a single 200 MHz clock domain; SMBus pins and the standby pin arrive asynchronously.
 */
// What this block does
// - Convert continuously, alternating local and remote channels
// - Local result keeps upper eight bits only
// - Remote result: 11 bits split over two registers
// - Add signed 11-bit correction to remote result
// - Correction registers reset to zero
// - High and low limits for both channels
// - Compare each result, flag every violated limit
// - Alert low while unmasked flag is set
// - Host controls standby, alert mask, conversion rate
// - Host reads back every register over SMBus
// - Measured values reset to minus 128 degrees
// - Normal power-up: fresh results before first comparison
// - Standby power-up: compare defaults, trip low flags
// - Leave standby, read status, clears if within limits
// - Average sixteen raw samples per stored result
// - Standby pin high is normal, low standby
// - One code step is one eighth degree
// - Saturate corrected remote result, never wrap
package temp_monitor_pkg;

    // Register pointer offsets (same offset for read and write)
    localparam logic [7:0] OFS_LOCAL_TEMP   = 8'h00;
    localparam logic [7:0] OFS_REMOTE_UPPER = 8'h01;
    localparam logic [7:0] OFS_STATUS       = 8'h02;
    localparam logic [7:0] OFS_CONFIG       = 8'h03;
    localparam logic [7:0] OFS_RATE         = 8'h04;
    localparam logic [7:0] OFS_LOCAL_HIGH   = 8'h05;
    localparam logic [7:0] OFS_LOCAL_LOW    = 8'h06;
    localparam logic [7:0] OFS_REM_HIGH_UP  = 8'h07;
    localparam logic [7:0] OFS_REM_LOW_UP   = 8'h08;
    localparam logic [7:0] OFS_REMOTE_LOWER = 8'h10;
    localparam logic [7:0] OFS_CORR_UPPER   = 8'h11;
    localparam logic [7:0] OFS_CORR_LOWER   = 8'h12;
    localparam logic [7:0] OFS_REM_HIGH_LO  = 8'h13;
    localparam logic [7:0] OFS_REM_LOW_LO   = 8'h14;

    // Reset values
    localparam logic [7:0]  RST_LOCAL_TEMP  = 8'h80;    // Minus 128 degrees
    localparam logic [10:0] RST_REMOTE_TEMP = 11'h400;  // Minus 128 degrees
    localparam logic [7:0]  RST_CORR        = 8'h00;
    localparam logic [7:0]  RST_CONFIG      = 8'h00;
    localparam logic [7:0]  RST_RATE        = 8'h07;
    localparam logic [7:0]  RST_LOCAL_HIGH  = 8'h7F;
    localparam logic [7:0]  RST_LOCAL_LOW   = 8'h00;
    localparam logic [10:0] RST_REM_HIGH    = 11'h3FF;
    localparam logic [10:0] RST_REM_LOW     = 11'h000;

    // Status and configuration bit positions
    localparam int ST_LOCAL_HIGH  = 6;
    localparam int ST_LOCAL_LOW   = 5;
    localparam int ST_REMOTE_HIGH = 4;
    localparam int ST_REMOTE_LOW  = 3;
    localparam int CFG_MASK_ALERT = 7;
    localparam int CFG_STANDBY    = 6;

    // Result arithmetic
    localparam int TEMP_W       = 11;  // Code width, 0.125 degree per step
    localparam int AVG_SHIFT    = 4;   // Sixteen samples per result
    localparam logic [3:0] AVG_LAST = 4'hF;

    // Timing
    localparam int CLK_PERIOD_NS     = 5;
    localparam int RATE_UNIT_NS      = 1000000;  // Shortest idle gap, 1 ms
    localparam int RATE_UNIT_CYCLES  = RATE_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [1:0] START_SETTLE = 2'h3;  // Cycles to fill pin synchronisers

    // Raw sample from the converter front end
    typedef struct packed {
        logic                valid;
        logic [TEMP_W-1:0]   code;
    } raw_sample_s;

    // Conversion sequencer states, Gray from C_START through C_LOCAL and C_REMOTE to C_WAIT; C_WAIT back to C_LOCAL flips two bits
    typedef enum logic [2:0] {
        C_START  = 3'b000,
        C_LOCAL  = 3'b001,
        C_REMOTE = 3'b011,
        C_WAIT   = 3'b010,
        C_STANDBY_SELECT_N   = 3'b110
    } conv_e;

    // SMBus byte engine states
    typedef enum logic [2:0] {
        B_IDLE  = 3'b000,
        B_ADDR  = 3'b001,
        B_ACK   = 3'b011,
        B_WDATA = 3'b010,
        B_RDATA = 3'b110,
        B_RACK  = 3'b111
    } bus_e;

endpackage

// >>> verilog/temp_monitor_core.sv
/*
 * Two-channel temperature monitor core: conversion sequencer with 16-sample averaging,
 * remote correction with saturation, limit compare, sticky status, alert, SMBus slave.
 * Assumes raw samples arrive on clk from the front end; SMBus and standby pins are async.
 */
`timescale 1ns/1ps
module temp_monitor_core
    import temp_monitor_pkg::*;
#(
    parameter logic [6:0] SMBUS_ADDR  = 7'h4C,           // Arbitrary default address
    parameter int         RATE_CYCLES = RATE_UNIT_CYCLES // Shortest idle gap in cycles
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    // Front end
    input  wire temp_monitor_pkg::raw_sample_s raw_in,
    output logic                             chan_remote,
    // Standby pin
    input  wire logic                        standby_select_n,
    // SMBus clock and data
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    // Alert, open drain
    output logic                             alert_n_out,
    output logic                             alert_n_oe
);
    import temp_monitor_pkg::*;

    // Complete state of the block
    typedef struct packed {
        conv_e        cst;          // Sequencer state
        logic [1:0]   settle;       // Start-up settle counter
        logic [3:0]   nsamp;        // Samples taken this conversion
        logic [14:0]  acc;          // Averaging accumulator
        logic [31:0]  wait_cnt;     // Idle gap countdown
        logic [7:0]   local_temp;   // Local result
        logic [10:0]  remote_temp;  // Remote result
        logic [7:0]   corr_up;      // Correction upper byte
        logic [7:0]   corr_lo;      // Correction lower byte
        logic [7:0]   cfg;          // Configuration
        logic [7:0]   rate;         // Conversion rate code
        logic [7:0]   lim_lh;       // Local high limit
        logic [7:0]   lim_ll;       // Local low limit
        logic [10:0]  lim_rh;       // Remote high limit
        logic [10:0]  lim_rl;       // Remote low limit
        logic [7:0]   flags;        // Sticky status
        bus_e         bst;          // SMBus state
        logic [3:0]   bit_cnt;      // Bits in current byte
        logic [7:0]   shreg;        // SMBus shift register
        logic         is_read;      // Current transfer reads
        logic         got_ptr;      // Pointer byte received
        logic [7:0]   ptr;          // Register pointer
        logic         sda_drv;      // Pull SDA low
        logic         alert_drv;    // Pull alert low
        logic [1:0]   scl_s;        // SCL synchroniser
        logic [1:0]   sda_s;        // SDA synchroniser
        logic [1:0]   standby_select_n_s;       // Standby pin synchroniser
        logic         scl_prev;     // SCL last sample
        logic         sda_prev;     // SDA last sample
    } state_s;

    state_s state_q;  // Registered state
    state_s state_d;  // Next state

    // Signed compare of a result against a limit pair; returns {high, low}
    function automatic logic [1:0] limit_check(input logic [10:0] v,
                                               input logic [10:0] hi,
                                               input logic [10:0] lo);
        limit_check = {$signed(v) > $signed(hi), $signed(v) < $signed(lo)};
    endfunction

    // Read-back value at a pointer
    function automatic logic [7:0] read_reg(input logic [7:0] p, input state_s s);
        case (p)
            OFS_LOCAL_TEMP:   read_reg = s.local_temp;
            OFS_REMOTE_UPPER: read_reg = s.remote_temp[10:3];
            OFS_REMOTE_LOWER: read_reg = {s.remote_temp[2:0], 5'h00};
            OFS_STATUS:       read_reg = s.flags;
            OFS_CONFIG:       read_reg = s.cfg;
            OFS_RATE:         read_reg = s.rate;
            OFS_LOCAL_HIGH:   read_reg = s.lim_lh;
            OFS_LOCAL_LOW:    read_reg = s.lim_ll;
            OFS_REM_HIGH_UP:  read_reg = s.lim_rh[10:3];
            OFS_REM_LOW_UP:   read_reg = s.lim_rl[10:3];
            OFS_REM_HIGH_LO:  read_reg = {s.lim_rh[2:0], 5'h00};
            OFS_REM_LOW_LO:   read_reg = {s.lim_rl[2:0], 5'h00};
            OFS_CORR_UPPER:   read_reg = s.corr_up;
            OFS_CORR_LOWER:   read_reg = s.corr_lo;
            default:          read_reg = 8'h00;
        endcase
    endfunction

    logic         standby;      // Effective standby
    logic         scl_rise;     // SCL rising edge seen
    logic         scl_fall;     // SCL falling edge seen
    logic         bus_start;    // Start condition
    logic         bus_stop;     // Stop condition
    logic [14:0]  acc_sum;      // Accumulator including current sample
    logic [10:0]  avg;          // Sixteen-sample mean
    logic [12:0]  rem_sum;      // Mean plus correction, signed
    logic [10:0]  rem_new;      // Saturated remote result
    logic [7:0]   flag_set;     // Flags raised this cycle
    logic         flag_clr;     // Status read clears flags
    logic [7:0]   tx_byte;      // Byte loaded for transmit

    // Edge and condition detection on synchronised pins
    always_comb begin
        standby   = ~state_q.standby_select_n_s[1] | state_q.cfg[CFG_STANDBY];
        scl_rise  = state_q.scl_s[1] & ~state_q.scl_prev;
        scl_fall  = ~state_q.scl_s[1] & state_q.scl_prev;
        bus_start = state_q.scl_s[1] & state_q.scl_prev & state_q.sda_prev & ~state_q.sda_s[1];
        bus_stop  = state_q.scl_s[1] & state_q.scl_prev & ~state_q.sda_prev & state_q.sda_s[1];
    end

    // Averaging and remote correction arithmetic
    always_comb begin
        acc_sum = state_q.acc + {4'h0, raw_in.code};
        avg     = acc_sum[14:AVG_SHIFT];
        rem_sum = {2'b00, avg}
                + {{2{state_q.corr_up[7]}}, state_q.corr_up, state_q.corr_lo[7:5]};
        if ($signed(rem_sum) > $signed(13'h03FF)) begin
            rem_new = 11'h3FF;
        end else if ($signed(rem_sum) < $signed(13'h1C00)) begin
            rem_new = 11'h400;
        end else begin
            rem_new = rem_sum[10:0];
        end
    end

    // Next-state logic
    always_comb begin
        state_d  = state_q;
        flag_set = 8'h00;
        flag_clr = 1'b0;
        tx_byte  = read_reg(state_q.ptr, state_q);

        // Pin synchronisers
        state_d.scl_s    = {state_q.scl_s[0], scl_in};
        state_d.sda_s    = {state_q.sda_s[0], sda_in};
        state_d.standby_select_n_s   = {state_q.standby_select_n_s[0], standby_select_n};
        state_d.scl_prev = state_q.scl_s[1];
        state_d.sda_prev = state_q.sda_s[1];

        // Conversion sequencer
        case (state_q.cst)
            C_START: begin
                if (state_q.settle != START_SETTLE) begin
                    state_d.settle = state_q.settle + 2'h1;
                end else if (standby) begin
                    // Compare power-up defaults without converting
                    flag_set[ST_LOCAL_HIGH:ST_LOCAL_LOW] =
                        limit_check({state_q.local_temp, 3'h0},
                                    {state_q.lim_lh, 3'h0},
                                    {state_q.lim_ll, 3'h0});
                    flag_set[ST_REMOTE_HIGH:ST_REMOTE_LOW] =
                        limit_check(state_q.remote_temp, state_q.lim_rh,
                                    state_q.lim_rl);
                    state_d.cst = C_STANDBY_SELECT_N;
                end else begin
                    state_d.cst = C_LOCAL;
                end
            end
            C_LOCAL, C_REMOTE: begin
                if (raw_in.valid) begin
                    state_d.acc   = acc_sum;
                    state_d.nsamp = state_q.nsamp + 4'h1;
                    if (state_q.nsamp == AVG_LAST) begin
                        state_d.acc = 15'h0000;
                        if (state_q.cst == C_LOCAL) begin
                            state_d.local_temp = avg[10:3];
                            flag_set[ST_LOCAL_HIGH:ST_LOCAL_LOW] =
                                limit_check({avg[10:3], 3'h0},
                                            {state_q.lim_lh, 3'h0},
                                            {state_q.lim_ll, 3'h0});
                            state_d.cst = C_REMOTE;
                        end else begin
                            state_d.remote_temp = rem_new;
                            flag_set[ST_REMOTE_HIGH:ST_REMOTE_LOW] =
                                limit_check(rem_new, state_q.lim_rh,
                                            state_q.lim_rl);
                            state_d.wait_cnt = RATE_CYCLES << (3'h7 - state_q.rate[2:0]);
                            state_d.cst = C_WAIT;
                        end
                    end
                end
            end
            C_WAIT: begin
                if (standby) begin
                    state_d.cst = C_STANDBY_SELECT_N;
                end else if (state_q.wait_cnt == 32'h0) begin
                    state_d.cst = C_LOCAL;
                end else begin
                    state_d.wait_cnt = state_q.wait_cnt - 32'h1;
                end
            end
            C_STANDBY_SELECT_N: begin
                state_d.nsamp = 4'h0;
                state_d.acc   = 15'h0000;
                if (!standby) begin
                    state_d.cst = C_LOCAL;
                end
            end
            default: state_d.cst = C_START;
        endcase

        // SMBus byte engine
        if (bus_start) begin
            state_d.bst     = B_ADDR;
            state_d.bit_cnt = 4'h0;
            state_d.got_ptr = 1'b0;
            state_d.sda_drv = 1'b0;
        end else if (bus_stop) begin
            state_d.bst     = B_IDLE;
            state_d.sda_drv = 1'b0;
        end else begin
            case (state_q.bst)
                B_IDLE: state_d.sda_drv = 1'b0;
                B_ADDR, B_WDATA: begin
                    if (scl_rise) begin
                        state_d.shreg   = {state_q.shreg[6:0], state_q.sda_s[1]};
                        state_d.bit_cnt = state_q.bit_cnt + 4'h1;
                    end else if (scl_fall && state_q.bit_cnt == 4'h8) begin
                        state_d.bit_cnt = 4'h0;
                        if (state_q.bst == B_ADDR) begin
                            if (state_q.shreg[7:1] == SMBUS_ADDR) begin
                                state_d.is_read = state_q.shreg[0];
                                state_d.sda_drv = 1'b1;
                                state_d.bst     = B_ACK;
                            end else begin
                                state_d.bst = B_IDLE;
                            end
                        end else begin
                            state_d.sda_drv = 1'b1;
                            state_d.bst     = B_ACK;
                            if (!state_q.got_ptr) begin
                                state_d.ptr     = state_q.shreg;
                                state_d.got_ptr = 1'b1;
                            end else begin
                                case (state_q.ptr)
                                    OFS_CONFIG:      state_d.cfg     = state_q.shreg;
                                    OFS_RATE:        state_d.rate    = state_q.shreg;
                                    OFS_LOCAL_HIGH:  state_d.lim_lh  = state_q.shreg;
                                    OFS_LOCAL_LOW:   state_d.lim_ll  = state_q.shreg;
                                    OFS_REM_HIGH_UP: state_d.lim_rh[10:3] = state_q.shreg;
                                    OFS_REM_LOW_UP:  state_d.lim_rl[10:3] = state_q.shreg;
                                    OFS_REM_HIGH_LO: state_d.lim_rh[2:0]  = state_q.shreg[7:5];
                                    OFS_REM_LOW_LO:  state_d.lim_rl[2:0]  = state_q.shreg[7:5];
                                    OFS_CORR_UPPER:  state_d.corr_up = state_q.shreg;
                                    OFS_CORR_LOWER:  state_d.corr_lo = state_q.shreg;
                                    default: ;
                                endcase
                            end
                        end
                    end
                end
                B_ACK, B_RACK: begin
                    if (scl_rise && state_q.bst == B_RACK && state_q.sda_s[1]) begin
                        state_d.bst = B_IDLE;  // Master ended the read
                    end else if (scl_fall) begin
                        state_d.sda_drv = 1'b0;
                        if (state_q.is_read) begin
                            // Load next byte and present its first bit
                            flag_clr        = (state_q.ptr == OFS_STATUS);
                            state_d.shreg   = {tx_byte[6:0], 1'b0};
                            state_d.sda_drv = ~tx_byte[7];
                            state_d.bit_cnt = 4'h1;
                            state_d.bst     = B_RDATA;
                        end else begin
                            state_d.bst = B_WDATA;
                        end
                    end
                end
                B_RDATA: begin
                    if (scl_fall) begin
                        if (state_q.bit_cnt == 4'h8) begin
                            state_d.sda_drv = 1'b0;
                            state_d.bst     = B_RACK;
                        end else begin
                            state_d.sda_drv = ~state_q.shreg[7];
                            state_d.shreg   = {state_q.shreg[6:0], 1'b0};
                            state_d.bit_cnt = state_q.bit_cnt + 4'h1;
                        end
                    end
                end
                default: state_d.bst = B_IDLE;
            endcase
        end

        // Sticky flags; a new event wins over a status-read clear
        state_d.flags = (flag_clr ? 8'h00 : state_q.flags) | flag_set;
        state_d.alert_drv = (|state_d.flags) & ~state_q.cfg[CFG_MASK_ALERT];
        if (state_d.bst == B_IDLE) begin
            state_d.sda_drv = 1'b0;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q             <= '0;
            state_q.cst         <= C_START;
            state_q.bst         <= B_IDLE;
            state_q.local_temp  <= RST_LOCAL_TEMP;
            state_q.remote_temp <= RST_REMOTE_TEMP;
            state_q.corr_up     <= RST_CORR;
            state_q.corr_lo     <= RST_CORR;
            state_q.cfg         <= RST_CONFIG;
            state_q.rate        <= RST_RATE;
            state_q.lim_lh      <= RST_LOCAL_HIGH;
            state_q.lim_ll      <= RST_LOCAL_LOW;
            state_q.lim_rh      <= RST_REM_HIGH;
            state_q.lim_rl      <= RST_REM_LOW;
            state_q.scl_s       <= 2'b11;
            state_q.sda_s       <= 2'b11;
            state_q.standby_select_n_s      <= 2'b11;
            state_q.scl_prev    <= 1'b1;
            state_q.sda_prev    <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs
    always_comb begin
        chan_remote = (state_q.cst == C_REMOTE);
        sda_out     = 1'b0;
        sda_oe      = state_q.sda_drv;
        alert_n_out = 1'b0;
        alert_n_oe  = state_q.alert_drv;
    end

endmodule // temp_monitor_core

// >>> bench/temp_monitor_sva.sv
/* Port checker for the temperature monitor core.
   Assumes one clock domain; bound from the bench top. */
`timescale 1ns/1ps
module temp_monitor_sva
    import temp_monitor_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Watched ports
    input wire raw_sample_s raw_in,
    input wire logic        chan_remote,
    input wire logic        standby_select_n,
    input wire logic        scl_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        alert_n_out,
    input wire logic        alert_n_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [4:0] rem_cnt_q;  // Samples taken in the current remote slot
    // Count samples while the remote channel is selected
    always_ff @(posedge clk) begin
        rem_cnt_q <= (sys_rst || !chan_remote) ? 5'h00 : rem_cnt_q + {4'h0, raw_in.valid};
    end
    AST_SDA_OPEN_DRAIN: assert property (sda_out == 1'b0)
        else $error("sda_out high");
    AST_ALERT_OPEN_DRAIN: assert property (alert_n_out == 1'b0)
        else $error("alert_n_out high");
    AST_RESET_IDLE: assert property (disable iff (1'b0)
        sys_rst |=> !sda_oe && !alert_n_oe && !chan_remote) else $error("busy after reset");
    AST_REMOTE_SIXTEEN: assert property ($fell(chan_remote) |-> rem_cnt_q == 5'h10)
        else $error("remote slot sample count wrong");
    AST_LOCAL_NEXT: assert property ($fell(chan_remote) |=> !chan_remote [*8])
        else $error("remote reselected too soon");
    AST_STANDBY_HOLDS: assert property ($rose(chan_remote) |-> $past(standby_select_n, 3))
        else $error("conversion in standby");
    AST_POWERUP_ALERT: assert property ($fell(sys_rst) && !standby_select_n
        |-> ##[1:10] alert_n_oe) else $error("no alert after standby power-up");
    AST_SDA_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data moved while clock high");
endmodule // temp_monitor_sva

// >>> bench/smbus_host_model.sv
/* SMBus host model: register writes and single-byte reads, MSB first.
   Assumes a pulled-up data wire resolved by the bench. */
`timescale 1ns/1ps
module smbus_host_model
    import temp_monitor_pkg::*;
#(
    parameter logic [6:0] ADDR = 7'h4C  // Target address, arbitrary
) (
    // Clock and wire
    input  wire logic  clk,
    input  wire logic  sda_line,
    output logic       scl,
    output logic       sda_drv,
    // Read result strobe
    output logic       rd_valid,
    output logic [7:0] rd_data
);
    // Idle bus: clock and data released high
    initial {scl, sda_drv, rd_valid, rd_data} = 11'h600;
    // Start (lvl 0) or stop (lvl 1): data moves while clock is high
    task automatic cond(input logic lvl);
        repeat (4) @(posedge clk);
        sda_drv <= ~lvl;
        repeat (12) @(posedge clk);
        scl <= 1'b1;
        repeat (16) @(posedge clk);
        sda_drv <= lvl;
        repeat (16) @(posedge clk);
        scl <= lvl;
    endtask
    // Nine bits; a one in the ninth releases the ack slot
    task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            repeat (2) @(posedge clk);
            sda_drv <= tx[i];
            repeat (14) @(posedge clk);
            scl <= 1'b1;
            repeat (8) @(posedge clk);
            rx[i] = sda_line;
            repeat (8) @(posedge clk);
            scl <= 1'b0;
        end
    endtask
    // Pointer write, then a data byte, or a stop and a fresh start for the read
    task automatic xfer(input logic rd, input logic [7:0] ptr, input logic [7:0] val);
        logic [8:0] rx;
        cond(1'b0);
        byte_io({ADDR, 2'b01}, rx);
        byte_io({ptr, 1'b1}, rx);
        if (rd) begin
            cond(1'b1);
            cond(1'b0);
            byte_io({ADDR, 2'b11}, rx);
        end
        byte_io(rd ? 9'h1FF : {val, 1'b1}, rx);
        rd_data <= rx[8:1];
        rd_valid <= rd;
        @(posedge clk);
        rd_valid <= 1'b0;
        cond(1'b1);
    endtask
endmodule // smbus_host_model

// >>> bench/temp_monitor_core_bench.sv
/* Bench top: front end stimulus, SMBus host, queued read checks.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/1ps
module temp_monitor_core_bench;
    import temp_monitor_pkg::*;
    logic        clk, sys_rst, standby_select_n, raw_valid, flip;
    logic        chan_remote, sda_out, sda_oe, alert_n_out, alert_n_oe, scl, sda_drv, rd_valid;
    logic [7:0]  rd_data;
    logic [10:0] lbase, rbase;        // Front end code per channel
    logic [7:0]  exp_q[$];            // Expected read bytes
    int          error_cnt = 0;
    int          tests_run = 0;
    int          seed = 91;
    wire logic   sda_line = sda_drv & ~sda_oe;  // Pulled-up wire
    raw_sample_s raw_in;
    // Code follows the selected channel, alternating between base and base plus two each cycle
    assign raw_in = {raw_valid, (chan_remote === 1'b1 ? rbase : lbase) + {9'h000, flip, 1'b0}};
    always @(posedge clk) flip <= ~flip;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    temp_monitor_core #(.RATE_CYCLES(20)) i_temp_monitor_core (.clk(clk), .sys_rst(sys_rst),
        .raw_in(raw_in), .chan_remote(chan_remote), .standby_select_n(standby_select_n),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe));
    smbus_host_model i_smbus_host_model (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv), .rd_valid(rd_valid), .rd_data(rd_data));
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        exp_q.push_back(exp);
        i_smbus_host_model.xfer(1'b1, ptr, 8'h00);
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
        i_smbus_host_model.xfer(1'b0, ptr, val);
    endtask
    // Each byte read is compared with the oldest note
    always @(posedge clk) if (rd_valid === 1'b1) check(rd_data, exp_q.pop_front());
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial begin
        {sys_rst, standby_select_n, raw_valid, flip} = 4'h8;
        lbase = 11'h100 + 11'($random(seed) & 32'h1FF);
        rbase = 11'h100 + 11'($random(seed) & 32'h0FF);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (20) @(posedge clk);
        check(alert_n_oe, 1'b1);
        rd(OFS_LOCAL_TEMP, RST_LOCAL_TEMP);
        rd(OFS_REMOTE_UPPER, RST_REMOTE_TEMP[10:3]);
        rd(OFS_CORR_LOWER, RST_CORR);
        wr(OFS_LOCAL_LOW, 8'h80);
        wr(OFS_REM_LOW_UP, 8'h80);
        rd(OFS_REM_LOW_UP, 8'h80);
        rd(OFS_STATUS, 8'h28);
        check(alert_n_oe, 1'b0);
        wr(OFS_CORR_UPPER, 8'h7F);
        wr(OFS_CORR_LOWER, 8'hE0);
        standby_select_n <= 1'b1;
        raw_valid <= 1'b1;
        repeat (300) @(posedge clk);
        rd(OFS_LOCAL_TEMP, 8'((lbase + 11'h001) >> 3));
        rd(OFS_REMOTE_UPPER, 8'h7F);
        rd(OFS_REMOTE_LOWER, 8'hE0);
        rd(OFS_STATUS, 8'h00);
        check(alert_n_oe, 1'b0);
        wr(OFS_LOCAL_HIGH, 8'h00);
        repeat (300) @(posedge clk);
        check(alert_n_oe, 1'b1);
        rd(OFS_STATUS, 8'h40);
        wr(OFS_CONFIG, 8'hC0);
        repeat (300) @(posedge clk);
        check(alert_n_oe, 1'b0);
        rd(8'h20, 8'h00);
        rd(OFS_RATE, RST_RATE);
        // Reset again in standby; leaving standby keeps the flags until read
        sys_rst <= 1'b1;
        standby_select_n <= 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (20) @(posedge clk);
        check(alert_n_oe, 1'b1);
        standby_select_n <= 1'b1;
        repeat (300) @(posedge clk);
        check(alert_n_oe, 1'b1);
        rd(OFS_STATUS, 8'h28);
        check(alert_n_oe, 1'b0);
        summarize();
    end
endmodule // temp_monitor_core_bench
bind temp_monitor_core temp_monitor_sva i_temp_monitor_sva (.clk(clk), .sys_rst(sys_rst),
    .raw_in(raw_in), .chan_remote(chan_remote), .standby_select_n(standby_select_n),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .alert_n_out(alert_n_out),
    .alert_n_oe(alert_n_oe));
